// ==== rtl/vbi_defs.svh ====
// Register indices, field positions, reset values and timing counts of the VBI data slicer.
// Assumes a 25 MHz processing clock and at most one video sample per clock.
`ifndef VBI_DEFS_SVH
`define VBI_DEFS_SVH
`define VBI_IDX_GLOBAL 8'h40
`define VBI_IDX_LINE_FIRST 8'h41
`define VBI_IDX_LINE_LAST 8'h57
`define VBI_IDX_SLICER_HORIZONTAL_OFFSET_LO 8'h59
`define VBI_IDX_SLICER_VERTICAL_OFFSET_LO 8'h5A
`define VBI_IDX_OFF_HI 8'h5B
`define VBI_IDX_FRAMING 8'h5C
`define VBI_IDX_STATUS 8'h5E
`define VBI_ERRCNT_MSB 1
`define VBI_ERRCNT_LSB 0
`define VBI_SLICER_HORIZONTAL_OFFSET_HI_MSB 2
`define VBI_SLICER_VERTICAL_OFFSET_HI_BIT 4
`define VBI_SLICER_FIELD_OFFSET_BIT 7
`define VBI_GLOBAL_RST 8'h00
`define VBI_LINE_RST 8'hFF
`define VBI_SLICER_HORIZONTAL_OFFSET_RST 11'h000
`define VBI_SLICER_VERTICAL_OFFSET_RST 9'h000
`define VBI_FRAMING_RST 8'h27
`define VBI_LINES 23
`define VBI_LAST_LINE 9'h018
`define VBI_FIRST_LINE 9'h002
`define VBI_SECTION_BYTES 56
`define VBI_HEADER_BYTES 3
`define VBI_SAMPLE_HZ 64'd25000000
`define VBI_RATE_TTX625 64'd6937500
`define VBI_RATE_TTX525 64'd5727200
`define VBI_RATE_CC625 64'd500000
`define VBI_RATE_CC525 64'd503000
`define VBI_RATE_5M 64'd5000000
`define VBI_RATE_VITC625 64'd1812500
`define VBI_RATE_VITC525 64'd1789800
`define VBI_DTO_ONE 64'd16777216
`define VBI_DTO_HALF 24'h800000
`define VBI_RUNIN_BITS 8'h10
`define VBI_FC_WINDOW_BITS 8'h20
`define VBI_FC_TTX 24'h000027
`define VBI_FC_CC 24'h000001
`define VBI_FC_VPS 24'h009951
`define VBI_FC_WSS 24'h1E3C1F
`endif

// ==== rtl/vbi_pkg.sv ====
// Types shared by the VBI data slicer: bus carriers, video input, output stream and state.
// Assumes vbi_defs.svh supplies every number.
package vbi_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_WAIT_H = 3'b001, ST_RUNIN = 3'b010, ST_FRAME = 3'b011, ST_DATA = 3'b100
  } slice_state_t;
  typedef enum logic [1:0] {FCW_DISABLE = 2'b00, FCW_FIXED = 2'b01, FCW_OPEN = 2'b10} fc_window_t;
  typedef enum logic [2:0] {
    REG_NONE = 3'b000, REG_GLOBAL = 3'b001, REG_LINE = 3'b010, REG_SLICER_HORIZONTAL_OFFSET_LO = 3'b011,
    REG_SLICER_VERTICAL_OFFSET_LO = 3'b100, REG_OFF_HI = 3'b101, REG_FRAMING = 3'b110, REG_STATUS = 3'b111
  } reg_sel_t;
  typedef struct packed {
    logic [23:0] inc;
    logic [23:0] fc;
    logic [4:0] fc_len;
    fc_window_t window;
    logic ham;
  } std_param_t;
  typedef struct packed {
    logic awvalid; logic [11:0] awaddr; logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic bready; logic arvalid; logic [11:0] araddr; logic rready;
  } axil_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } axil_rsp_t;
  typedef struct packed {
    logic sample_valid; logic [7:0] sample;
    logic horizontal_reference; logic vertical_trigger; logic field_id;
  } video_in_t;
  typedef struct packed {
    logic valid; logic header; logic [7:0] data;
  } vbi_out_t;
  typedef struct packed {
    axil_rsp_t rsp;
    logic aw_held; logic w_held; logic [11:0] awaddr; logic [31:0] wdata; logic [3:0] wstrb;
    logic [7:0] global_cfg; logic [22:0][7:0] line_std;
    logic [10:0] slicer_horizontal_offset; logic [8:0] slicer_vertical_offset; logic slicer_field_offset; logic [7:0] prog_fc;
    logic horizontal_reference_d; logic vtrig_d; logic field; logic [8:0] vcnt; logic [10:0] hcnt;
    slice_state_t st; logic [3:0] code; logic [8:0] line_no; std_param_t prm;
    logic [23:0] phase; logic [23:0] sr; logic [7:0] bitcnt; logic lvl;
    logic [7:0] vmin; logic [7:0] vmax; logic [7:0] byte_sh; logic [2:0] byte_bits;
    logic [5:0] byte_cnt; logic [1:0] ham_err;
    logic [1:0][55:0][7:0] mem; logic wsel; logic [1:0] full;
    logic [1:0][5:0] sec_len; logic [1:0][8:0] sec_line; logic [1:0][3:0] sec_code;
    logic [1:0] sec_field; logic rsel; logic [5:0] ridx;
    logic [1:0][8:0] fifo; logic [1:0] fcnt; logic overflow;
  } vbi_state_t;
endpackage

// ==== rtl/vbi_data_slicer.sv ====
// VBI data slicer: per-line standard selection, run-in phase recovery, framing search,
// byte assembly into a two-section line buffer and a header-led byte stream.
// Assumes the decoder front end runs on aclk and the stream sink is on aclk too.
//
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "vbi_defs.svh"

// How it works
// - Recover phase in run-in, slice, assemble bytes.
// - Two buffer sections of 56 bytes each.
// - Lines 2-24 use per-field 4-bit codes.
// - Line 24 code covers rest of field.
// - Horizontal, vertical, field offsets position the window.
// - Offsets count from falling trigger edges.
// - Teletext rates, framing 27H, Hamming checked.
// - Closed caption rates, framing 001.
// - VPS and WSS at 5 Mbit/s.
// - Time codes with programmable framing.
// - Types 0110, 0111, 1111 are not sliced.
// - Types 1011, 1110: open window, programmable.
// - Whole line collected before transfer requested.
// - Streamed line led by number/standard header.
module vbi_data_slicer import vbi_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite register port
  input wire axil_req_t axi_req,
  output axil_rsp_t axi_rsp,
  // Digitised video and trigger references from the decoder
  input wire video_in_t video_in,
  // Sliced byte stream
  output vbi_out_t vbi_out,
  input wire logic out_ready
);

  vbi_state_t s;
  vbi_state_t n;

  function automatic reg_sel_t reg_decode(input logic [11:0] addr);
    logic [7:0] idx;
    idx = addr[9:2];
    if (addr[11:10] != 2'b00 || addr[1:0] != 2'b00) return REG_NONE;
    if (idx >= `VBI_IDX_LINE_FIRST && idx <= `VBI_IDX_LINE_LAST) return REG_LINE;
    case (idx)
      `VBI_IDX_GLOBAL: return REG_GLOBAL;
      `VBI_IDX_SLICER_HORIZONTAL_OFFSET_LO: return REG_SLICER_HORIZONTAL_OFFSET_LO;
      `VBI_IDX_SLICER_VERTICAL_OFFSET_LO: return REG_SLICER_VERTICAL_OFFSET_LO;
      `VBI_IDX_OFF_HI: return REG_OFF_HI;
      `VBI_IDX_FRAMING: return REG_FRAMING;
      `VBI_IDX_STATUS: return REG_STATUS;
      default: return REG_NONE;
    endcase
  endfunction

  function automatic logic [4:0] line_index(input logic [11:0] addr);
    logic [7:0] d;
    d = addr[9:2] - `VBI_IDX_LINE_FIRST;
    return d[4:0];
  endfunction

  function automatic logic [23:0] dto_inc(input logic [63:0] rate);
    logic [63:0] q;
    q = rate * `VBI_DTO_ONE / `VBI_SAMPLE_HZ;
    return q[23:0];
  endfunction

  // Maps a data type code to its bit rate, framing code and framing window.
  function automatic std_param_t std_param(input logic [3:0] code, input logic [7:0] pfc);
    std_param_t p;
    p = '{inc: dto_inc(`VBI_RATE_5M), fc: {16'h0000, pfc}, fc_len: 5'd8,
          window: FCW_OPEN, ham: 1'b0};
    case (code)
      4'h0: p = '{dto_inc(`VBI_RATE_TTX625), `VBI_FC_TTX, 5'd8, FCW_FIXED, 1'b1};
      4'h4: p = '{dto_inc(`VBI_RATE_TTX525), `VBI_FC_TTX, 5'd8, FCW_FIXED, 1'b1};
      4'h1: p = '{dto_inc(`VBI_RATE_CC625), `VBI_FC_CC, 5'd3, FCW_FIXED, 1'b0};
      4'h5: p = '{dto_inc(`VBI_RATE_CC525), `VBI_FC_CC, 5'd3, FCW_FIXED, 1'b0};
      4'h2: p = '{dto_inc(`VBI_RATE_5M), `VBI_FC_VPS, 5'd16, FCW_FIXED, 1'b0};
      4'h3: p = '{dto_inc(`VBI_RATE_5M), `VBI_FC_WSS, 5'd24, FCW_FIXED, 1'b0};
      4'h6, 4'h7, 4'hF: p.window = FCW_DISABLE;
      4'h8: p = '{dto_inc(`VBI_RATE_TTX625), {16'h0000, pfc}, 5'd8, FCW_FIXED, 1'b0};
      4'h9: p = '{dto_inc(`VBI_RATE_VITC625), {16'h0000, pfc}, 5'd8, FCW_FIXED, 1'b0};
      4'hA: p = '{dto_inc(`VBI_RATE_VITC525), {16'h0000, pfc}, 5'd8, FCW_FIXED, 1'b0};
      4'hC, 4'hD: p = '{dto_inc(`VBI_RATE_TTX525), {16'h0000, pfc}, 5'd8, FCW_FIXED, 1'b0};
      default: p.window = FCW_OPEN;
    endcase
    return p;
  endfunction

  // Odd-parity Hamming 8/4 byte check; all four tests must pass.
  function automatic logic ham84_ok(input logic [7:0] b);
    return (b[0] ^ b[1] ^ b[5] ^ b[7]) & (b[1] ^ b[2] ^ b[3] ^ b[7]) &
           (b[1] ^ b[3] ^ b[4] ^ b[5]) & (^b);
  endfunction

  reg_sel_t wsel_reg;
  reg_sel_t rsel_reg;
  logic hfall;
  logic vfall;
  logic [8:0] vnext;
  logic [8:0] line_calc;
  logic [4:0] lcr_idx;
  logic [7:0] lcr_byte;
  logic [3:0] code_calc;
  std_param_t prm_calc;
  logic [8:0] thr_sum;
  logic bitv;
  logic [24:0] acc;
  logic [23:0] sr_new;
  logic [23:0] fc_mask;
  logic [7:0] byte_new;
  logic do_commit;
  logic [5:0] c_len;
  logic [1:0] c_err;
  logic [1:0] c1;
  logic pop;
  logic [7:0] rd_byte;
  logic [5:0] rd_data_idx;

  assign axi_rsp = s.rsp;
  assign vbi_out = '{valid: (s.fcnt != 2'd0), header: s.fifo[0][8], data: s.fifo[0][7:0]};

  always_comb begin
    n = s;
    wsel_reg = reg_decode(s.awaddr);
    rsel_reg = reg_decode(axi_req.araddr);
    do_commit = 1'b0;
    c_len = s.byte_cnt;
    c_err = s.ham_err;
    vnext = 9'h000;
    line_calc = 9'h000;
    lcr_idx = 5'd0;
    lcr_byte = 8'h00;
    code_calc = 4'hF;
    prm_calc = s.prm;
    thr_sum = {1'b0, s.vmax} + {1'b0, s.vmin};
    bitv = video_in.sample > thr_sum[8:1];
    acc = {1'b0, s.phase} + {1'b0, s.prm.inc};
    sr_new = {s.sr[22:0], bitv};
    fc_mask = 24'(~(25'h1FFFFFF << s.prm.fc_len));
    byte_new = {bitv, s.byte_sh[7:1]};
    rd_byte = 8'h00;
    rd_data_idx = 6'd0;

    // Register writes: address and data are taken in either order.
    if (axi_req.awvalid && s.rsp.awready) begin
      n.awaddr = axi_req.awaddr;
      n.aw_held = 1'b1;
      n.rsp.awready = 1'b0;
    end
    if (axi_req.wvalid && s.rsp.wready) begin
      n.wdata = axi_req.wdata;
      n.wstrb = axi_req.wstrb;
      n.w_held = 1'b1;
      n.rsp.wready = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.rsp.bvalid) begin
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = (wsel_reg == REG_NONE) ? 2'b10 : 2'b00;
      if (s.wstrb[0]) begin
        case (wsel_reg)
          REG_GLOBAL: n.global_cfg = s.wdata[7:0];
          REG_LINE: n.line_std[line_index(s.awaddr)] = s.wdata[7:0];
          REG_SLICER_HORIZONTAL_OFFSET_LO: n.slicer_horizontal_offset[7:0] = s.wdata[7:0];
          REG_SLICER_VERTICAL_OFFSET_LO: n.slicer_vertical_offset[7:0] = s.wdata[7:0];
          REG_OFF_HI: begin
            n.slicer_horizontal_offset[10:8] = s.wdata[`VBI_SLICER_HORIZONTAL_OFFSET_HI_MSB:0];
            n.slicer_vertical_offset[8] = s.wdata[`VBI_SLICER_VERTICAL_OFFSET_HI_BIT];
            n.slicer_field_offset = s.wdata[`VBI_SLICER_FIELD_OFFSET_BIT];
          end
          REG_FRAMING: n.prog_fc = s.wdata[7:0];
          REG_STATUS: if (s.wdata[0]) n.overflow = 1'b0;
          default: n.overflow = s.overflow;
        endcase
      end
    end
    if (s.rsp.bvalid && axi_req.bready) begin
      n.rsp.bvalid = 1'b0;
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.rsp.awready = 1'b1;
      n.rsp.wready = 1'b1;
    end

    // Register reads.
    if (axi_req.arvalid && s.rsp.arready) begin
      n.rsp.arready = 1'b0;
      n.rsp.rvalid = 1'b1;
      n.rsp.rresp = (rsel_reg == REG_NONE) ? 2'b10 : 2'b00;
      case (rsel_reg)
        REG_GLOBAL: n.rsp.rdata = {24'h000000, s.global_cfg};
        REG_LINE: n.rsp.rdata = {24'h000000, s.line_std[line_index(axi_req.araddr)]};
        REG_SLICER_HORIZONTAL_OFFSET_LO: n.rsp.rdata = {24'h000000, s.slicer_horizontal_offset[7:0]};
        REG_SLICER_VERTICAL_OFFSET_LO: n.rsp.rdata = {24'h000000, s.slicer_vertical_offset[7:0]};
        REG_OFF_HI: n.rsp.rdata = {24'h000000, s.slicer_field_offset, 2'b00, s.slicer_vertical_offset[8], 1'b0, s.slicer_horizontal_offset[10:8]};
        REG_FRAMING: n.rsp.rdata = {24'h000000, s.prog_fc};
        REG_STATUS: n.rsp.rdata = {12'h000, s.line_no, s.st, s.full, s.wsel, s.rsel, 3'b000,
                                   s.overflow};
        default: n.rsp.rdata = 32'h00000000;
      endcase
    end
    if (s.rsp.rvalid && axi_req.rready) begin
      n.rsp.rvalid = 1'b0;
      n.rsp.arready = 1'b1;
    end

    // Trigger edges: offsets count from falling edges of the references.
    n.horizontal_reference_d = video_in.horizontal_reference;
    n.vtrig_d = video_in.vertical_trigger;
    hfall = s.horizontal_reference_d & ~video_in.horizontal_reference;
    vfall = s.vtrig_d & ~video_in.vertical_trigger;
    if (vfall) begin
      n.vcnt = 9'h000;
      n.field = video_in.field_id ^ s.slicer_field_offset;
    end

    if (hfall) begin
      if (s.st == ST_DATA && s.byte_cnt != 6'd0) do_commit = 1'b1;
      vnext = vfall ? 9'h000 : s.vcnt + 9'h001;
      n.vcnt = vnext;
      n.hcnt = 11'h000;
      line_calc = vnext - s.slicer_vertical_offset;
      if (line_calc > `VBI_LAST_LINE) begin
        lcr_idx = 5'(`VBI_LINES - 1);
      end else if (line_calc >= `VBI_FIRST_LINE) begin
        lcr_idx = 5'(line_calc - `VBI_FIRST_LINE);
      end
      lcr_byte = s.line_std[lcr_idx];
      code_calc = n.field ? lcr_byte[7:4] : lcr_byte[3:0];
      prm_calc = std_param(code_calc, s.prog_fc);
      n.line_no = line_calc;
      n.code = code_calc;
      n.prm = prm_calc;
      n.st = ST_IDLE;
      if (vnext >= s.slicer_vertical_offset && line_calc >= `VBI_FIRST_LINE && prm_calc.window != FCW_DISABLE) begin
        // A line is dropped whole if the section wsel names before any commit on this edge is still waiting.
        if (s.full[s.wsel]) n.overflow = 1'b1;
        else n.st = ST_WAIT_H;
      end
    end else if (video_in.sample_valid) begin
      n.hcnt = s.hcnt + 11'h001;
      case (s.st)
        ST_WAIT_H: begin
          if (s.hcnt == s.slicer_horizontal_offset) begin
            n.st = ST_RUNIN;
            n.phase = 24'h000000;
            n.bitcnt = 8'h00;
            n.vmin = 8'hFF;
            n.vmax = 8'h00;
            n.lvl = 1'b0;
            n.sr = 24'h000000;
            n.byte_cnt = 6'd0;
            n.byte_bits = 3'd0;
            n.ham_err = 2'd0;
          end
        end
        ST_RUNIN, ST_FRAME, ST_DATA: begin
          if (s.st == ST_RUNIN) begin
            if (video_in.sample < s.vmin) n.vmin = video_in.sample;
            if (video_in.sample > s.vmax) n.vmax = video_in.sample;
          end
          n.lvl = bitv;
          if (s.st == ST_RUNIN && bitv != s.lvl) begin
            // Each run-in edge realigns the bit clock so sampling lands mid-bit.
            n.phase = `VBI_DTO_HALF;
          end else begin
            n.phase = acc[23:0];
            if (acc[24]) begin
              n.sr = sr_new;
              n.bitcnt = (s.bitcnt == 8'hFF) ? s.bitcnt : s.bitcnt + 8'h01;
              case (s.st)
                ST_RUNIN: begin
                  if (s.bitcnt + 8'h01 >= `VBI_RUNIN_BITS) begin
                    n.st = ST_FRAME;
                    n.bitcnt = 8'h00;
                  end
                end
                ST_FRAME: begin
                  if (((sr_new ^ s.prm.fc) & fc_mask) == 24'h000000) begin
                    n.st = ST_DATA;
                  end else if (s.prm.window == FCW_FIXED && s.bitcnt >= `VBI_FC_WINDOW_BITS) begin
                    n.st = ST_IDLE;
                  end
                end
                default: begin
                  n.byte_sh = byte_new;
                  n.byte_bits = s.byte_bits + 3'd1;
                  if (s.byte_bits == 3'd7) begin
                    n.mem[s.wsel][s.byte_cnt] = byte_new;
                    n.byte_cnt = s.byte_cnt + 6'd1;
                    if (s.prm.ham && s.byte_cnt < 6'd2 && !ham84_ok(byte_new)) begin
                      n.ham_err = s.ham_err + 2'd1;
                    end
                    if (s.byte_cnt == 6'(`VBI_SECTION_BYTES - 1)) begin
                      do_commit = 1'b1;
                      c_len = n.byte_cnt;
                      c_err = n.ham_err;
                      n.st = ST_IDLE;
                    end
                  end
                end
              endcase
            end
          end
        end
        default: n.st = ST_IDLE;
      endcase
    end

    // Two-entry output buffer; the reader stalls when both entries are still taken after this cycle's pop.
    pop = (s.fcnt != 2'd0) && out_ready;
    c1 = s.fcnt - {1'b0, pop};
    if (pop) n.fifo[0] = s.fifo[1];
    n.fcnt = c1;
    if (s.full[s.rsel] && c1 != 2'd2) begin
      rd_data_idx = s.ridx - 6'(`VBI_HEADER_BYTES);
      case (s.ridx)
        6'd0: rd_byte = s.sec_line[s.rsel][7:0];
        6'd1: rd_byte = {s.sec_line[s.rsel][8], s.sec_field[s.rsel], 2'b00, s.sec_code[s.rsel]};
        6'd2: rd_byte = {2'b00, s.sec_len[s.rsel]};
        default: rd_byte = s.mem[s.rsel][rd_data_idx];
      endcase
      n.fifo[c1[0]] = {(s.ridx < 6'(`VBI_HEADER_BYTES)), rd_byte};
      n.fcnt = c1 + 2'd1;
      n.ridx = s.ridx + 6'd1;
      if (s.ridx == s.sec_len[s.rsel] + 6'(`VBI_HEADER_BYTES - 1)) begin
        n.full[s.rsel] = 1'b0;
        n.ridx = 6'd0;
        n.rsel = ~s.rsel;
      end
    end

    // A finished line becomes visible to the reader only when complete.
    if (do_commit && (!s.prm.ham || c_err <= s.global_cfg[`VBI_ERRCNT_MSB:`VBI_ERRCNT_LSB])) begin
      n.full[s.wsel] = 1'b1;
      n.sec_len[s.wsel] = c_len;
      n.sec_line[s.wsel] = s.line_no;
      n.sec_code[s.wsel] = s.code;
      n.sec_field[s.wsel] = s.field;
      n.wsel = ~s.wsel;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
      s.global_cfg <= `VBI_GLOBAL_RST;
      s.line_std <= {`VBI_LINES{`VBI_LINE_RST}};
      s.slicer_horizontal_offset <= `VBI_SLICER_HORIZONTAL_OFFSET_RST;
      s.slicer_vertical_offset <= `VBI_SLICER_VERTICAL_OFFSET_RST;
      s.prog_fc <= `VBI_FRAMING_RST;
      s.code <= 4'hF;
    end else begin
      s <= n;
    end
  end

endmodule // vbi_data_slicer

// ==== dv/vbi_slicer_asserts.sv ====
// Assertion checker for the VBI slicer ports: register bus timing and stream framing.
// Assumes one clock domain and a bind onto vbi_data_slicer.
`timescale 1ns/1ps
module vbi_slicer_asserts import vbi_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire axil_req_t axi_req,
  input wire axil_rsp_t axi_rsp,
  // Video and stream
  input wire video_in_t video_in,
  input wire vbi_out_t vbi_out,
  input wire logic out_ready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic tk;
  logic seen_q;
  logic [1:0] hidx_q;
  logic [5:0] len_q;
  logic [6:0] dcnt_q;
  assign tk = vbi_out.valid && out_ready;
  // Tracks the position inside a line, so that gaps and lengths can be judged.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seen_q <= 1'b0;
      hidx_q <= 2'h0;
      len_q <= 6'h00;
      dcnt_q <= 7'h00;
    end else if (tk && vbi_out.header) begin
      seen_q <= 1'b1;
      hidx_q <= (hidx_q == 2'h2) ? 2'h0 : hidx_q + 2'h1;
      len_q <= (hidx_q == 2'h2) ? vbi_out.data[5:0] : len_q;
      dcnt_q <= 7'h00;
    end else if (tk) begin
      dcnt_q <= dcnt_q + 7'h01;
    end
  end
  sequence s_wr_both;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence s_rd_take;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  sequence s_hdr_take;
    tk && vbi_out.header;
  endsequence
  property p_b_answer;
    s_wr_both |=> !axi_rsp.awready && !axi_rsp.wready ##1 axi_rsp.bvalid;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write response late");
  property p_b_hold;
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_answer;
    s_rd_take |=> axi_rsp.rvalid && !axi_rsp.arready;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read data late");
  property p_unmapped;
    s_rd_take ##0 axi_req.araddr == 12'h160 |=> axi_rsp.rresp == 2'h2 && axi_rsp.rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole read not refused");
  property p_out_hold;
    vbi_out.valid && !out_ready |=> vbi_out.valid && $stable(vbi_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("stalled byte changed");
  property p_hdr_first;
    $rose(vbi_out.valid) |-> vbi_out.header && hidx_q == 2'h0;
  endproperty
  a_hdr_first: assert property (p_hdr_first) else $error("line not led by header");
  property p_hdr_run;
    s_hdr_take ##0 hidx_q != 2'h2 |=> vbi_out.valid && vbi_out.header;
  endproperty
  a_hdr_run: assert property (p_hdr_run) else $error("header broken up");
  property p_data_run;
    tk && !vbi_out.header && dcnt_q + 7'h01 < {1'b0, len_q} |=> vbi_out.valid && !vbi_out.header;
  endproperty
  a_data_run: assert property (p_data_run) else $error("gap inside line data");
  property p_len_max;
    s_hdr_take ##0 hidx_q == 2'h2 |-> vbi_out.data <= 8'h38 && vbi_out.data != 8'h00;
  endproperty
  a_len_max: assert property (p_len_max) else $error("line length out of range");
  property p_len_match;
    s_hdr_take ##0 (hidx_q == 2'h0 && seen_q) |-> dcnt_q == {1'b0, len_q};
  endproperty
  a_len_match: assert property (p_len_match) else $error("data count differs");
endmodule // vbi_slicer_asserts

// ==== dv/vbi_video_source.sv ====
// Decoder front end model: field and line triggers and bit-serial samples.
// Assumes one sample per clock at 25 MHz, so a 5 Mbit/s bit spans five samples.
`timescale 1ns/1ps
module vbi_video_source import vbi_pkg::*; (
  // Clock and control
  input wire logic aclk,
  input wire logic go,
  input wire logic fld,
  input wire logic [31:0] payload,
  // Front end outputs
  output video_in_t video_in,
  output logic busy
);
  localparam int LINES = 6;
  localparam int LINE_CYC = 2600;
  logic [479:0] bits;
  // Invalid samples toggle so that a stale level can never be sliced by luck.
  task automatic tick(input logic v, input logic b);
    @(posedge aclk);
    video_in.sample_valid <= v;
    video_in.sample <= v ? (b ? 8'hC0 : 8'h20) : ~video_in.sample;
  endtask
  initial begin
    video_in = {1'b0, 8'h5A, 1'b1, 1'b1, 1'b0};
    busy = 1'b0;
    forever begin
      tick(1'b0, 1'b0);
      if (go) begin
        busy <= 1'b1;
        // The framing word leaves most significant bit first, so it is stored bit-reversed.
        bits = {416'h0, payload, 16'h8A99, 16'h5555};
        video_in.field_id <= fld;
        video_in.vertical_trigger <= 1'b0;
        for (int k = 0; k < LINES; k++) begin
          video_in.horizontal_reference <= 1'b1;
          repeat (8) tick(1'b0, 1'b0);
          video_in.horizontal_reference <= 1'b0;
          for (int i = 0; i < LINE_CYC; i++)
            tick(1'b1, i < 2400 ? bits[i / 5] : 1'b0);
        end
        video_in.horizontal_reference <= 1'b1;
        video_in.vertical_trigger <= 1'b1;
        busy <= 1'b0;
      end
    end
  end
endmodule // vbi_video_source

// ==== dv/tb.sv ====
// Top testbench: register checks over AXI4-Lite, then sliced fields with a stalling sink.
// Assumes the checker and the front end model are compiled before this file.
`timescale 1ns/1ps
`include "vbi_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb import vbi_pkg::*; ;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  axil_req_t req = '0;
  axil_rsp_t rsp;
  video_in_t vin;
  vbi_out_t vout;
  logic out_ready = 1'b0;
  logic go = 1'b0;
  logic fld = 1'b0;
  logic busy;
  logic [31:0] payload = 32'h0;
  integer seed = 17;
  int miscompares = 0;
  int n_tests = 0;
  logic [8:0] got[$];
  logic [8:0] exp_q[$];
  logic [7:0] ridx[5] = '{`VBI_IDX_GLOBAL, `VBI_IDX_FRAMING, `VBI_IDX_SLICER_HORIZONTAL_OFFSET_LO,
                          `VBI_IDX_SLICER_VERTICAL_OFFSET_LO, `VBI_IDX_OFF_HI};
  logic [7:0] rrst[5] = '{`VBI_GLOBAL_RST, `VBI_FRAMING_RST, 8'h00, 8'h00, 8'h00};
  logic [7:0] mask[5] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h97};
  logic [7:0] lines[5] = '{8'hFF, 8'h66, 8'h22, 8'h27, 8'hFF};
  logic fid[3] = '{1'b0, 1'b1, 1'b0};
  logic fo[3] = '{1'b0, 1'b0, 1'b1};
  always #20 aclk = ~aclk;
  vbi_data_slicer u_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .video_in(vin), .vbi_out(vout), .out_ready(out_ready));
  vbi_video_source u_src (.aclk(aclk), .go(go), .fld(fld), .payload(payload),
    .video_in(vin), .busy(busy));
  always @(posedge aclk) begin
    if (aresetn && vout.valid && out_ready)
      got.push_back({vout.header, vout.data});
    out_ready <= ($random(seed) & 3) != 0;
  end
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'b00, i, 2'b00};
  endfunction
  function automatic logic [7:0] hdr1(input logic f, input logic [3:0] code);
    return {1'b0, f, 2'b00, code};
  endfunction
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic to_chk(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      $display("BAD wait exp done got timeout");
      test_done();
    end
  endtask
  task automatic axi(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    logic aw;
    logic w;
    logic ar;
    logic hs;
    int n;
    @(posedge aclk);
    aw = wr;
    w = wr;
    ar = !wr;
    n = 0;
    req.awvalid <= wr;
    req.wvalid <= wr;
    req.bready <= 1'b0;
    req.arvalid <= !wr;
    req.rready <= 1'b0;
    req.awaddr <= a;
    req.wdata <= d;
    req.araddr <= a;
    while ((aw || w || ar) && n < 200) begin
      @(posedge aclk);
      n++;
      if (aw && rsp.awready === 1'b1) begin
        aw = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w && rsp.wready === 1'b1) begin
        w = 1'b0;
        req.wvalid <= 1'b0;
      end
      if (ar && rsp.arready === 1'b1) begin
        ar = 1'b0;
        req.arvalid <= 1'b0;
      end
    end
    // Ready is raised after a random delay and then held, so a waiting answer is exercised.
    do begin
      @(posedge aclk);
      n++;
      hs = wr ? (rsp.bvalid & req.bready) : (rsp.rvalid & req.rready);
      if (hs !== 1'b1 && $random(seed) % 2 != 0) begin
        req.bready <= wr;
        req.rready <= !wr;
      end
    end while (hs !== 1'b1 && n < 200);
    to_chk(n, 200);
    q = rsp.rdata;
    r = wr ? rsp.bresp : rsp.rresp;
    req.bready <= 1'b0;
    req.rready <= 1'b0;
  endtask
  task automatic add_line(input logic [7:0] ln, input logic f, input logic [31:0] p);
    exp_q.push_back({1'b1, ln});
    exp_q.push_back({1'b1, hdr1(f, 4'h2)});
    exp_q.push_back({1'b1, 8'h38});
    for (int k = 0; k < 56; k++)
      exp_q.push_back({1'b0, k < 4 ? p[8 * k +: 8] : 8'h00});
  endtask
  initial begin
    logic [31:0] q;
    logic [1:0] r;
    logic [7:0] v;
    logic f;
    int n;
    req.wstrb <= 4'hF;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      axi(1'b0, ad(ridx[i]), 32'h0, q, r);
      `CHK("reset value", {24'h0, rrst[i]}, q)
    end
    axi(1'b0, ad(`VBI_IDX_LINE_FIRST), 32'h0, q, r);
    `CHK("line reset", {24'h0, `VBI_LINE_RST}, q)
    axi(1'b0, ad(8'h58), 32'h0, q, r);
    `CHK("hole read", 34'h200000000, {r, q})
    axi(1'b1, ad(8'h58), 32'hFF, q, r);
    `CHK("hole write", 2'h2, r)
    $display("test reset_map done");
    for (int i = 0; i < 5; i++) begin
      v = 8'($random(seed));
      axi(1'b1, ad(ridx[i]), {24'h0, v}, q, r);
      axi(1'b0, ad(ridx[i]), 32'h0, q, r);
      `CHK("readback", {24'h0, v & mask[i]}, q)
      axi(1'b1, ad(ridx[i]), {24'h0, rrst[i]}, q, r);
    end
    for (int i = 0; i < 5; i++)
      axi(1'b1, ad(`VBI_IDX_LINE_FIRST + 8'(i)), {24'h0, lines[i]}, q, r);
    axi(1'b1, ad(`VBI_IDX_LINE_LAST), 32'hFF, q, r);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      f = fid[i] ^ fo[i];
      axi(1'b1, ad(`VBI_IDX_OFF_HI), {24'h0, fo[i], 7'h00}, q, r);
      @(posedge aclk);
      payload <= 32'($random(seed));
      fld <= fid[i];
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      add_line(8'h04, f, payload);
      if (f)
        add_line(8'h05, f, payload);
      n = 0;
      while ((busy !== 1'b0 || n < 4 || got.size() < exp_q.size()) && n < 40000) begin
        @(posedge aclk);
        n++;
      end
      to_chk(n, 40000);
      `CHK("stream length", exp_q.size(), got.size())
      for (int k = 0; k < exp_q.size() && k < got.size(); k++)
        `CHK("stream byte", exp_q[k], got[k])
      got.delete();
      exp_q.delete();
      $display("test field %0d done", i);
    end
    axi(1'b0, ad(`VBI_IDX_STATUS), 32'h0, q, r);
    `CHK("status idle", 3'h0, {q[7:6], q[0]})
    test_done();
  end
endmodule // tb
bind vbi_data_slicer vbi_slicer_asserts u_chk (.aclk(aclk), .aresetn(aresetn),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .video_in(video_in), .vbi_out(vbi_out),
  .out_ready(out_ready));
